//--- core/dma_enable_control.sv
/*
  Transfer enable control and status for one receive and one transmit
  channel of a serial peripheral, with its peripheral bus register slave.
  Assumes: bus signals come from logic on the same clock; reads answer
  one cycle after the strobe; unmapped addresses read zero, writes ignored.
  clk_en is synchronous to clock and freezes every flop while low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dma_enable_consts.svh"

module dma_enable_control
  import dma_enable_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W,
  parameter int COUNT_W = `COUNT_W
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Peripheral register bus
  input wire logic periph_select,
  input wire logic periph_stb,
  input wire logic periph_write,
  input wire logic [ADDR_W-1:0] periph_add,
  input wire logic [`DATA_W-1:0] pwdata,
  output logic [`DATA_W-1:0] prdata,
  // Peripheral handshakes and counts
  input wire logic periph_rx_rdy,
  input wire logic periph_tx_rdy,
  input wire logic [COUNT_W-1:0] transmit_count,
  // Request and enable status outputs
  output logic rx_xfer_req,
  output logic tx_xfer_req,
  output logic rx_enabled,
  output logic tx_enabled
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // Wider addresses are accepted, but only the low byte is decoded, so the
  // map repeats across the upper address space
  if (ADDR_W < `ADDR_W || COUNT_W < 1) begin : g_bad_p
    $error("dma_enable_control: ADDR_W too small or COUNT_W zero");
  end

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Decode nets, all combinational from the bus pins of our own clock
  bus_req_t bus; // Bundled request
  ctrl_cmd_t cmd; // Decoded control write
  logic wr_ctrl; // Write to control register
  logic rd_any; // Read access this cycle

  // Bundle the bus pins so the decode reads as one request
  assign bus = '{sel: periph_select, stb: periph_stb, write: periph_write,
                 addr: periph_add[`ADDR_W-1:0], wdata: pwdata};
  // Only the control offset takes writes; any other write is dropped
  assign wr_ctrl = bus.sel && bus.stb && bus.write && bus.addr == `CTRL_OFFSET;
  // Every read answers next cycle, mapped or not, so a master never stalls
  assign rd_any = bus.sel && bus.stb && !bus.write;

  // Field decode; a zero bit asserts nothing
  // Both bits of one direction may arrive together; precedence is below
  always_comb begin
    cmd.rx_on = wr_ctrl && bus.wdata[`RX_ENABLE_BIT];
    cmd.rx_off = wr_ctrl && bus.wdata[`RX_DISABLE_BIT];
    cmd.tx_on = wr_ctrl && bus.wdata[`TX_ENABLE_BIT];
    cmd.tx_off = wr_ctrl && bus.wdata[`TX_DISABLE_BIT];
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // One packed record holds every flop of this module
  top_state_t state_reg; // All registers of this module
  top_state_t state_next; // Their next values

  // Next-state logic for enables and read data
  always_comb begin
    state_next = state_reg;
    // Default: every register holds, which also covers zero command bits
    // Receive: disable wins, enable only when disable not set
    if (cmd.rx_off) begin
      state_next.rx_en = 1'b0;
    end else if (cmd.rx_on) begin
      state_next.rx_en = 1'b1;
    end
    // Transmit: same precedence as receive for a safe outcome
    if (cmd.tx_off) begin
      state_next.tx_en = 1'b0;
    end else if (cmd.tx_on) begin
      state_next.tx_en = 1'b1;
    end
    // No command bits set: enables hold as they are
    // Status comes from the registered enables, so a read in the same
    // cycle as a control write shows the value from before that write
    // Read data; control register is write-only and reads zero
    if (rd_any) begin
      state_next.rdata = `DATA_ZERO;
      if (bus.addr == `STAT_OFFSET) begin
        state_next.rdata[`STAT_RX_BIT] = state_reg.rx_en;
        state_next.rdata[`STAT_TX_BIT] = state_reg.tx_en;
      end
    end
  end

  // Registers; asynchronous reset clears both enables
  // Read data is cleared too, so a read straight after reset never sees a
  // stale status word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.rx_en <= `EN_RESET;
      state_reg.tx_en <= `EN_RESET;
      state_reg.rdata <= `DATA_ZERO;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Data outputs come straight from flops
  assign prdata = state_reg.rdata;
  assign rx_enabled = state_reg.rx_en;
  assign tx_enabled = state_reg.tx_en;
  // Receive request follows ready while enabled
  // Left combinational so a ready pulse is seen in its own cycle; only the
  // enable behind it is frozen by clk_en
  assign rx_xfer_req = state_reg.rx_en && periph_rx_rdy;

  // ----------------------------------------------------------------------
  // Transmit gate
  // ----------------------------------------------------------------------
  // The gate registers its request, so a change of enable, ready or count
  // shows on the transmit request one cycle later
  tx_request_gate #(
    .COUNT_W(COUNT_W)
  ) u_tx_gate (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .dir_enable(state_reg.tx_en),
    .periph_ready(periph_tx_rdy),
    .count(transmit_count),
    .xfer_req(tx_xfer_req)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Each check but enables_hold_a is gated by clk_en where the logic it guards is gated too
  rx_enable_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.rx_on && !cmd.rx_off |=> rx_enabled)
    else $error("receive enable not set");
  rx_disable_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.rx_off |=> !rx_enabled)
    else $error("receive disable not honoured");
  tx_enable_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.tx_on && !cmd.tx_off |=> tx_enabled)
    else $error("transmit enable not set");
  tx_disable_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.tx_off |=> !tx_enabled)
    else $error("transmit disable not honoured");
  enables_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(cmd.rx_on || cmd.rx_off || cmd.tx_on || cmd.tx_off)
    |=> $stable(rx_enabled) && $stable(tx_enabled))
    else $error("enable changed without command");
  rx_status_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_any && bus.addr == `STAT_OFFSET |=> prdata[`STAT_RX_BIT] == $past(rx_enabled))
    else $error("receive status wrong");
  tx_status_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_any && bus.addr == `STAT_OFFSET |=> prdata[`STAT_TX_BIT] == $past(tx_enabled))
    else $error("transmit status wrong");
  status_unused_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_any |=> (prdata & ~((32'h1 << `STAT_RX_BIT) | (32'h1 << `STAT_TX_BIT))) == `DATA_ZERO)
    else $error("unused status bits set");
  tx_both_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.tx_on && cmd.tx_off |=> !tx_enabled ##1 !tx_xfer_req)
    else $error("transmit enabled by conflicting write");

  // Request outputs against the commands that drive them
  // A receive disable silences the receive request on the next cycle
  rx_off_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.rx_off |=> !rx_xfer_req)
    else $error("receive request after disable");
  // A receive enable lets the next ready through at once
  rx_on_request_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.rx_on && !cmd.rx_off |=> !periph_rx_rdy || rx_xfer_req)
    else $error("receive request missing after enable");
  // A transmit enable starts requests once ready and a count are present
  tx_on_request_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.tx_on && !cmd.tx_off ##1
    clk_en && periph_tx_rdy && transmit_count != COUNT_W'(0) |=> tx_xfer_req)
    else $error("transmit request missing after enable");
  // A transmit disable stops requests after the gate's own cycle
  tx_off_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cmd.tx_off ##1 clk_en |=> !tx_xfer_req)
    else $error("transmit request after disable");
  // No transmit request is ever built from a disabled direction
  tx_idle_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !tx_enabled |=> !tx_xfer_req)
    else $error("transmit request while disabled");
  // A low clock enable freezes every registered output
  clock_freeze_a: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(rx_enabled) && $stable(tx_enabled) && $stable(prdata) && $stable(tx_xfer_req))
    else $error("state moved while clock enable low");

endmodule

`default_nettype wire

//--- include/dma_enable_consts.svh
/*
  Offsets, field positions, reset values and counts for the transfer
  enable control and status block.
  Assumes: included by bare name from the package and the design files.
*/
`ifndef DMA_ENABLE_CONSTS_SVH
`define DMA_ENABLE_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map (word-aligned byte addresses within the channel pair)
// ----------------------------------------------------------------------
`define CTRL_OFFSET 8'h20
`define STAT_OFFSET 8'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RX_ENABLE_BIT 0
`define RX_DISABLE_BIT 1
`define TX_ENABLE_BIT 8
`define TX_DISABLE_BIT 9
`define STAT_RX_BIT 0
`define STAT_TX_BIT 8

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define ADDR_W 8
`define DATA_W 32
`define COUNT_W 16
`define EN_RESET 1'b0
`define COUNT_ZERO 16'h0000
`define DATA_ZERO 32'h0000_0000

`endif

//--- include/dma_enable_pkg.sv
/*
  Types shared by the transfer enable block and its transmit gate.
  Assumes: the constants header is on the include path.
*/
`include "dma_enable_consts.svh"

package dma_enable_pkg;

  // Peripheral bus request as seen on one edge
  typedef struct packed {
    logic sel;
    logic stb;
    logic write;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } bus_req_t;

  // Decoded control write, one pulse bit per field
  typedef struct packed {
    logic rx_on;
    logic rx_off;
    logic tx_on;
    logic tx_off;
  } ctrl_cmd_t;

  // Whole state of the top module
  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic [`DATA_W-1:0] rdata;
  } top_state_t;

  // Whole state of the transmit gate
  typedef struct packed {
    logic req;
  } gate_state_t;

endpackage

//--- core/tx_request_gate.sv
/*
  Transmit transfer gate: registers a transfer request, set one cycle after the
  direction is enabled, the peripheral is ready and the count is nonzero.
  Assumes: count and ready come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dma_enable_consts.svh"

module tx_request_gate
  import dma_enable_pkg::*;
#(
  parameter int COUNT_W = `COUNT_W
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Qualifiers
  input wire logic dir_enable,
  input wire logic periph_ready,
  input wire logic [COUNT_W-1:0] count,
  // Request out
  output logic xfer_req
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (COUNT_W < 1) begin : g_bad_w
    $error("tx_request_gate: COUNT_W must be at least 1");
  end

  gate_state_t state_reg; // Registered request
  gate_state_t state_next; // Its next value

  // Zero count stops transfers, any nonzero count lets ready through
  always_comb begin
    state_next = state_reg;
    state_next.req = dir_enable && periph_ready && (count != COUNT_W'(0));
  end

  // Register the request, frozen while clk_en is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign xfer_req = state_reg.req;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  zero_count_stops_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && count == COUNT_W'(0) |=> !xfer_req)
    else $error("request issued with zero count");
  ready_starts_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && dir_enable && periph_ready && count != COUNT_W'(0) |=> xfer_req)
    else $error("request missing with count and ready");

endmodule

`default_nettype wire

//--- verif/tb_dma_channel_enable_control.sv
/*
  Self-checking bench for the transfer enable control block.
  Assumes: constants header on the include path; 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dma_enable_consts.svh"
// ---------------------------------------------------------------
// Compare helper
// ---------------------------------------------------------------
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module tb_dma_channel_enable_control
  import dma_enable_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic clock, rst_n, clk_en, sel, stb, wr, rx_rdy, tx_rdy;
  logic [`ADDR_W-1:0] add;
  logic [`DATA_W-1:0] wd;
  logic [`COUNT_W-1:0] cnt;
  wire logic [`DATA_W-1:0] prdata;
  wire logic rx_req, tx_req, rx_en, tx_en;
  // Reference state: current, after the pending edge, expected request
  logic rx_m, tx_m, nrx, ntx, exp_tx;
  int mismatches, checked, i;
  logic [`DATA_W-1:0] d;

  dma_enable_control dut (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .periph_select(sel), .periph_stb(stb), .periph_write(wr),
    .periph_add(add), .pwdata(wd), .prdata(prdata),
    .periph_rx_rdy(rx_rdy), .periph_tx_rdy(tx_rdy), .transmit_count(cnt),
    .rx_xfer_req(rx_req), .tx_xfer_req(tx_req),
    .rx_enabled(rx_en), .tx_enabled(tx_en)
  );

  // Free-running clock, 25 ns period
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Expected status word from the reference state
  function automatic logic [`DATA_W-1:0] stat_word();
    stat_word = `DATA_ZERO;
    stat_word[`STAT_RX_BIT] = rx_m;
    stat_word[`STAT_TX_BIT] = tx_m;
  endfunction

  // Hand-picked control words: each enable field alone, both of a pair, and zero
  function automatic logic [`DATA_W-1:0] code_word(input int n);
    case (n)
      0: code_word = 32'h0000_0001;
      1: code_word = 32'h0000_0000;
      2: code_word = 32'h0000_0003;
      3: code_word = 32'h0000_0100;
      4: code_word = 32'h0000_0000;
      5: code_word = 32'h0000_0300;
      6: code_word = 32'h0000_0101;
      default: code_word = 32'h0000_0202;
    endcase
  endfunction

  // One clock: fresh handshakes, then check the requests and enables
  task automatic step();
    rx_rdy = 1'($urandom);
    tx_rdy = 1'($urandom);
    // Zero and full counts are the edges of the gate
    case ($urandom % 4)
      0: cnt = `COUNT_ZERO;
      1: cnt = 16'hffff;
      default: cnt = 16'($urandom);
    endcase
    // Frozen clock keeps the registered request as it was
    if (clk_en) exp_tx = tx_m & tx_rdy & (cnt != `COUNT_ZERO);
    @(posedge clock);
    #1;
    rx_m = nrx;
    tx_m = ntx;
    `CHK(tx_req, exp_tx)
    `CHK(rx_req, rx_m & rx_rdy)
    `CHK(({rx_en, tx_en}), ({rx_m, tx_m}))
  endtask

  // Bus access held over one taking edge; select stays up for back to back
  task automatic bus(input logic w, input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] v);
    sel = 1'b1;
    stb = 1'b1;
    wr = w;
    add = a;
    wd = v;
    nrx = rx_m;
    ntx = tx_m;
    // Disable beats enable in the same word
    if (w && clk_en && a == `CTRL_OFFSET) begin
      if (v[`RX_DISABLE_BIT]) nrx = 1'b0;
      else if (v[`RX_ENABLE_BIT]) nrx = 1'b1;
      if (v[`TX_DISABLE_BIT]) ntx = 1'b0;
      else if (v[`TX_ENABLE_BIT]) ntx = 1'b1;
    end
    step();
  endtask

  // Read and compare; only the status offset returns data
  task automatic rd(input logic [`ADDR_W-1:0] a);
    bus(1'b0, a, 32'($urandom));
    `CHK(prdata, (a == `STAT_OFFSET) ? stat_word() : `DATA_ZERO)
  endtask

  // Bus idle for one clock
  task automatic idle();
    sel = 1'b0;
    stb = 1'b0;
    nrx = rx_m;
    ntx = tx_m;
    step();
  endtask

  // Reset asserted off the edge; outputs clear at once
  task automatic do_reset();
    rst_n = 1'b0;
    {rx_m, tx_m, nrx, ntx, exp_tx} = 5'h00;
    #1;
    `CHK(({rx_en, tx_en, rx_req, tx_req, prdata}), 36'h0_0000_0000)
    repeat (4) @(posedge clock);
    #1;
    rst_n = 1'b1;
  endtask

  // Counts, verdict and end of run
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: whole sequence is under 160 cycles
  initial begin
    #(5000 * 25);
    mismatches++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {clk_en, sel, stb, wr, rx_rdy, tx_rdy} = 6'h00;
    {add, wd, cnt, mismatches, checked} = '0;
    // Start released so the reset in do_reset is a clean falling edge
    rst_n = 1'b1;
    void'($urandom(32'h04fbd675));
    #1;
    do_reset();
    clk_en = 1'b1;
    // Each enable code alone, both bits of a pair, both enables, both disables, and zero words
    for (i = 0; i < 8; i++) begin
      bus(1'b1, `CTRL_OFFSET, code_word(i));
      rd(`STAT_OFFSET);
    end
    // Control reads as zero, unmapped write ignored
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0101);
    bus(1'b1, 8'h28, 32'h0000_0202);
    rd(`CTRL_OFFSET);
    rd(8'h28);
    rd(`STAT_OFFSET);
    // Write while the clock is disabled has no effect
    clk_en = 1'b0;
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0202);
    idle();
    clk_en = 1'b1;
    rd(`STAT_OFFSET);
    // Random back to back traffic with stray bits
    for (i = 0; i < 120; i++) begin
      d = ($urandom % 2) ? 32'($urandom) : 32'($urandom) & 32'h0000_0303;
      case ($urandom % 4)
        0: rd(`STAT_OFFSET);
        1: rd(8'($urandom));
        2: idle();
        default: bus(1'b1, ($urandom % 8) ? `CTRL_OFFSET : 8'($urandom), d);
      endcase
    end
    // Second reset mid-run clears both enables
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0101);
    idle();
    do_reset();
    idle();
    rd(`STAT_OFFSET);
    end_of_test();
  end
endmodule
`default_nettype wire
